// ---- dspf_ireg_mem.sv ----
/*
 Shared constants for the serial port framer, and the indirect register memory.
 Assumes one clock domain; reads return data one clock after the enable.
*/
`timescale 1ns/10ps
package dspf_pkg;
   localparam int CLK_HZ = 100000000;
   localparam int SCLK_HZ = 11000000;
   localparam int SCLK_DIV = CLK_HZ / SCLK_HZ;
   localparam int SLOT_BITS = 16;
   localparam int SLOTS = 12;
   localparam int FRAME_BITS = SLOT_BITS * SLOTS;
   localparam int NCH = 5;
   localparam int CW_CLEAR = 15;
   localparam int CW_VALID_LSB = 8;
   localparam int CW_ACTIVE = 7;
   localparam int CW_READ = 6;
   localparam int CH_CAPTURE = 4;
   localparam int CH_PLAYBACK = 3;
   localparam int IDX_BITS = 6;
   localparam logic [5:0] IDX_CTRL = 6'h21;
   localparam logic [5:0] IDX_MBOX0 = 6'h2a;
   localparam logic [5:0] IDX_MBOX1 = 6'h2b;
   localparam int R33_ICPT_LSB = 3;
   localparam logic [7:0] R33_RESET = 8'h00;
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CONFIG = 4'h4;
   localparam logic [3:0] ADDR_IND_ADDR = 4'h8;
   localparam logic [3:0] ADDR_IND_DATA = 4'hc;
   localparam int CFG_MODEM = 0;
   localparam int CFG_CAPEQ = 1;
   localparam logic [1:0] CFG_RESET = 2'h0;
   typedef enum logic [2:0] {
      ST_PAD = 3'b001,
      ST_SYNC = 3'b010,
      ST_SLOTS = 3'b100
   } dspf_state_e;
endpackage : dspf_pkg

module dspf_ireg_mem #(
   parameter int AW = 6,
   parameter int DW = 16
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic we_i,
   input wire logic re_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wdata_i,
   output logic [DW-1:0] rdata_o
);
   logic [DW-1:0] mem [0:(2**AW)-1];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_o <= '0;
      end else if (re_i) begin
         rdata_o <= mem[addr_i];
      end
   end
endmodule : dspf_ireg_mem

// ---- dspf_port_framer.sv ----
/*
 Serial port framer: master of the sample/control port, with Avalon-MM registers.
 Assumes tx samples, valid, full and rate ticks come from logic on clk_i.
*/
// Local design decisions: the placing of the registers and the Avalon-MM register port.
// Summary of operation
// [RQ1] Slot 0 carries control in and status out; slot 1 carries indirect data.
// [RQ2] Slots 2-11 carry capture, playback, synth, port 1, port 0 pairs.
// [RQ3] Incoming slots 2-11 are dropped for pairs not in intercept mode.
// [RQ4] Every frame holds twelve slots of sixteen bits.
// [RQ5] Frame rate select in register 33 picks maximum or a channel rate.
// [RQ6] Slower rates pad idle clock periods after the slots, length varying.
// [RQ7] A channel whose rate equals frame rate shows valid and request at one.
// [RQ8] Five enables in register 33 turn on intercept per channel pair.
// [RQ9] Control word: clear, reserved, five valid-in flags, active, read, index.
// [RQ10] Each frame performs one indirect read or write at the given index.
// [RQ11] The active bit goes out to the power-down timer.
// [RQ12] Valid-in counts only with intercept on and a request last frame.
// [RQ13] Equal capture/playback rates let playback valid also validate capture.
// [RQ14] Modem mode takes capture from slot 3 only, copied to both channels.
// [RQ15] Partner drives reserved control bits as zero.
// [RQ16] Clear bit clears powerdown and config reset flags, else they hold.
// [RQ17] Status word: flags, valid-outs, mailboxes, request flags.
// [RQ18] Request is one when intercept is on and the input buffer not full.
// [RQ19] Mailbox flags follow last access to registers 42 and 43.
// [RQ20] Valid-out is one only when the slot pair carries valid samples.
// [RQ21] In modem mode capture valid-out covers slot 3 only.
// [RQ22] A 24-slot partner treats both halves as one identical frame.
// [RQ23] The device drives serial clock and frame sync.
// [RQ24] Bits launch after rising clock edges and are sampled on falling ones.
// [RQ25] Frame sync is one clock period high, one period before slot 0.
// [RQ26] Writes are refused while config reset is set, unless clear is sent.
// [RQ27] Slots shift most significant bit first, slot 0 right after sync.
// [RQ28] Control and slot 1 are acted on at the end of the frame.
`timescale 1ns/10ps
module dspf_port_framer #(
   parameter int SCLK_DIV = dspf_pkg::SCLK_DIV
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic serial_in_pin_i,
   output logic serial_clk_o,
   output logic serial_out_pin_o,
   output logic frame_sync_pin_o,
   input wire logic [159:0] tx_sample_i,
   input wire logic [4:0] tx_valid_i,
   input wire logic [4:0] sub_full_i,
   input wire logic [4:0] rate_tick_i,
   input wire logic powerdown_i,
   input wire logic config_reset_cmd_i,
   output logic [159:0] sub_sample_o,
   output logic [4:0] sub_strobe_o,
   output logic port_active_o
);
   localparam int HIGH_CYC = (SCLK_DIV + 1) / 2;
   localparam logic [7:0] DIV_LAST = 8'(SCLK_DIV - 1);
   localparam logic [7:0] LAST_BIT = 8'(dspf_pkg::FRAME_BITS - 1);
   localparam logic [7:0] PRE_LAST = 8'(dspf_pkg::FRAME_BITS - 2);

   function automatic logic [15:0] tx_word(input logic [3:0] n, input logic [15:0] st,
                                           input logic [15:0] ind, input logic [159:0] smp);
      if (n == 4'h0) return st;
      else if (n == 4'h1) return ind;
      else return smp[16*(n-2) +: 16];
   endfunction : tx_word

   function automatic logic [15:0] rx_slot(input logic [191:0] f, input int n);
      return f[191-16*n -: 16];
   endfunction : rx_slot

   logic [7:0] div_cnt, next_div_cnt;
   logic rise_en, fall_en;
   logic [2:0] sdi_sync;
   logic sdi_q;
   dspf_pkg::dspf_state_e state;
   logic [7:0] bit_cnt;
   logic [14:0] tx_shift;
   logic [191:0] rx_frame;
   logic pending, go, go_taken, slot0_load, eof_pulse, eof_d;
   logic [4:0] eq_mask, icpt_en, req_sent, req_prev, next_req, acc;
   logic [2:0] rate_sel;
   logic [7:0] reg33;
   logic mb0, mb1, pdn_flag, cfg_flag;
   logic [1:0] cfg_bits;
   logic [5:0] ind_addr;
   logic [15:0] ind_rdata_q, view33, next_status, cw, mem_rdata;
   logic port_re, port_we, rd33;
   logic av_ph, av_go, av_fire, av_ind, av_re, av_we;
   logic mem_we, mem_re;
   logic [5:0] mem_addr;
   logic [15:0] mem_wdata;
   logic [31:0] av_value;

   assign rate_sel = reg33[2:0];
   assign icpt_en = reg33[dspf_pkg::R33_ICPT_LSB +: dspf_pkg::NCH];
   assign view33 = {6'h00, mb1, mb0, reg33};
   assign cw = rx_slot(rx_frame, 0); // [RQ9]

   // Serial clock divider; rise and fall enables mark the clock edges
   assign next_div_cnt = (div_cnt == DIV_LAST) ? 8'h00 : div_cnt + 8'h01;
   assign rise_en = (next_div_cnt == 8'h00);
   assign fall_en = (next_div_cnt == 8'(HIGH_CYC));

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_cnt <= 8'h00;
         serial_clk_o <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         serial_clk_o <= (next_div_cnt < 8'(HIGH_CYC)); // [RQ23]
      end
   end

   // Serial input synchroniser with agreement filter
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sdi_sync <= 3'h0;
         sdi_q <= 1'b0;
      end else begin
         sdi_sync <= {sdi_sync[1:0], serial_in_pin_i};
         if (sdi_sync[1] == sdi_sync[2]) begin
            sdi_q <= sdi_sync[2];
         end
      end
   end

   // Rate matching
   always_comb begin
      for (int c = 0; c < dspf_pkg::NCH; c++) begin
         eq_mask[c] = (rate_sel == 3'(dspf_pkg::NCH - c)); // [RQ5]
      end
   end
   assign go = (eq_mask == 5'h00) || pending; // [RQ6]
   assign go_taken = rise_en && go &&
                     (state == dspf_pkg::ST_PAD ||
                      (state == dspf_pkg::ST_SLOTS && bit_cnt == PRE_LAST));
   assign slot0_load = rise_en && (state == dspf_pkg::ST_SYNC ||
                      (state == dspf_pkg::ST_SLOTS && bit_cnt == LAST_BIT && frame_sync_pin_o));
   assign eof_pulse = rise_en && state == dspf_pkg::ST_SLOTS && bit_cnt == LAST_BIT;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pending <= 1'b0;
      end else if ((rate_tick_i & eq_mask) != 5'h00) begin
         pending <= 1'b1;
      end else if (go_taken) begin
         pending <= 1'b0;
      end
   end

   assign next_req = eq_mask | (icpt_en & ~sub_full_i); // [RQ18] [RQ7]
   assign next_status = {pdn_flag, cfg_flag, 1'b0, tx_valid_i | eq_mask,
                         mb1, mb0, 1'b0, next_req}; // [RQ17] [RQ20] [RQ21] [RQ7]

   // Frame sequencer on serial clock rises
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state <= dspf_pkg::ST_PAD;
         bit_cnt <= 8'h00;
         frame_sync_pin_o <= 1'b0;
         serial_out_pin_o <= 1'b0;
         tx_shift <= 15'h0000;
      end else if (rise_en) begin
         case (state)
            dspf_pkg::ST_PAD: begin
               if (go) begin
                  frame_sync_pin_o <= 1'b1; // [RQ25]
                  state <= dspf_pkg::ST_SYNC;
               end
            end
            dspf_pkg::ST_SYNC: begin
               frame_sync_pin_o <= 1'b0;
               state <= dspf_pkg::ST_SLOTS;
               bit_cnt <= 8'h00;
               {serial_out_pin_o, tx_shift} <= next_status; // [RQ1] [RQ27]
            end
            dspf_pkg::ST_SLOTS: begin
               if (bit_cnt == LAST_BIT) begin
                  frame_sync_pin_o <= 1'b0;
                  bit_cnt <= 8'h00;
                  if (frame_sync_pin_o) begin
                     {serial_out_pin_o, tx_shift} <= next_status; // [RQ4]
                  end else begin
                     state <= dspf_pkg::ST_PAD; // [RQ6]
                     serial_out_pin_o <= 1'b0;
                  end
               end else begin
                  if (bit_cnt == PRE_LAST) begin
                     frame_sync_pin_o <= go; // [RQ25]
                  end
                  bit_cnt <= bit_cnt + 8'h01;
                  if (bit_cnt[3:0] == 4'hf) begin
                     {serial_out_pin_o, tx_shift} <=
                        tx_word(bit_cnt[7:4] + 4'h1, next_status, ind_rdata_q, tx_sample_i); // [RQ2]
                  end else begin
                     serial_out_pin_o <= tx_shift[14]; // [RQ24]
                     tx_shift <= {tx_shift[13:0], 1'b0};
                  end
               end
            end
            default: state <= dspf_pkg::ST_PAD;
         endcase
      end
   end

   // Receive shift on falling edges
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_frame <= '0;
      end else if (fall_en && state == dspf_pkg::ST_SLOTS) begin
         rx_frame <= {rx_frame[190:0], sdi_q}; // [RQ24] [RQ27]
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         req_sent <= 5'h00;
         req_prev <= 5'h00;
      end else if (slot0_load) begin
         req_sent <= next_req;
         req_prev <= req_sent;
      end
   end

   // End-of-frame control handling
   always_comb begin
      acc = icpt_en & req_prev & cw[dspf_pkg::CW_VALID_LSB +: dspf_pkg::NCH]; // [RQ12] [RQ3]
      if (cfg_bits[dspf_pkg::CFG_CAPEQ] && cw[dspf_pkg::CW_VALID_LSB + dspf_pkg::CH_PLAYBACK]) begin
         acc[dspf_pkg::CH_CAPTURE] = icpt_en[dspf_pkg::CH_CAPTURE] &
                                     req_prev[dspf_pkg::CH_CAPTURE]; // [RQ13]
      end
   end
   assign port_re = eof_pulse && cw[dspf_pkg::CW_READ]; // [RQ10] [RQ28]
   assign port_we = eof_pulse && !cw[dspf_pkg::CW_READ] &&
                    (!cfg_flag || cw[dspf_pkg::CW_CLEAR]); // [RQ26]

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sub_sample_o <= '0;
         sub_strobe_o <= 5'h00;
         port_active_o <= 1'b0;
      end else begin
         sub_strobe_o <= eof_pulse ? acc : 5'h00;
         if (eof_pulse) begin
            port_active_o <= cw[dspf_pkg::CW_ACTIVE]; // [RQ11]
            for (int n = 2; n < dspf_pkg::SLOTS; n++) begin
               if (acc[dspf_pkg::NCH - 1 - (n - 2) / 2]) begin
                  sub_sample_o[16*(n-2) +: 16] <= rx_slot(rx_frame, n); // [RQ2]
               end
            end
            if (acc[dspf_pkg::CH_CAPTURE] && cfg_bits[dspf_pkg::CFG_MODEM]) begin
               sub_sample_o[15:0] <= rx_slot(rx_frame, 3); // [RQ14]
            end
         end
      end
   end

   // Status flags; a set wins over the clear
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pdn_flag <= 1'b1;
         cfg_flag <= 1'b1;
      end else begin
         if (powerdown_i) pdn_flag <= 1'b1;
         else if (eof_pulse && cw[dspf_pkg::CW_CLEAR]) pdn_flag <= 1'b0; // [RQ16]
         if (config_reset_cmd_i) cfg_flag <= 1'b1;
         else if (eof_pulse && cw[dspf_pkg::CW_CLEAR]) cfg_flag <= 1'b0; // [RQ16]
      end
   end

   // Avalon slave: two-phase access, stalled on the frame-end cycle
   assign av_go = (avs_read_i || avs_write_i) && avs_waitrequest_o && !eof_pulse;
   assign av_fire = av_go && av_ph;
   assign av_ind = (avs_address_i == dspf_pkg::ADDR_IND_DATA) && ind_addr != dspf_pkg::IDX_CTRL;
   assign av_re = av_go && !av_ph && avs_read_i && av_ind;
   assign av_we = av_fire && avs_write_i && av_ind;

   always_comb begin
      case (avs_address_i)
         dspf_pkg::ADDR_STATUS:
            av_value = {22'h0, port_active_o, mb1, mb0, pdn_flag, cfg_flag, req_sent};
         dspf_pkg::ADDR_CONFIG: av_value = {30'h0, cfg_bits};
         dspf_pkg::ADDR_IND_ADDR: av_value = {26'h0, ind_addr};
         dspf_pkg::ADDR_IND_DATA:
            av_value = {16'h0, (ind_addr == dspf_pkg::IDX_CTRL) ? view33 : mem_rdata};
         default: av_value = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0;
         av_ph <= 1'b0;
      end else if (!avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b1;
      end else if (!av_go) begin
         av_ph <= 1'b0;
      end else if (!av_ph) begin
         av_ph <= 1'b1;
      end else begin
         av_ph <= 1'b0;
         avs_waitrequest_o <= 1'b0;
         avs_readdata_o <= avs_read_i ? av_value : 32'h0;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cfg_bits <= dspf_pkg::CFG_RESET;
         ind_addr <= 6'h00;
      end else if (av_fire && avs_write_i) begin
         if (avs_address_i == dspf_pkg::ADDR_CONFIG) cfg_bits <= avs_writedata_i[1:0];
         if (avs_address_i == dspf_pkg::ADDR_IND_ADDR) ind_addr <= avs_writedata_i[5:0];
      end
   end

   // Register 33 and mailboxes, reached from the port and from software
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg33 <= dspf_pkg::R33_RESET;
         mb0 <= 1'b0;
         mb1 <= 1'b0;
      end else if (eof_pulse) begin
         if (port_we && cw[5:0] == dspf_pkg::IDX_CTRL) reg33 <= mem_wdata[7:0]; // [RQ8]
         if ((port_we || port_re) && cw[5:0] == dspf_pkg::IDX_MBOX0) mb0 <= port_we; // [RQ19]
         if ((port_we || port_re) && cw[5:0] == dspf_pkg::IDX_MBOX1) mb1 <= port_we; // [RQ19]
      end else if (av_fire && avs_address_i == dspf_pkg::ADDR_IND_DATA) begin
         if (avs_write_i && ind_addr == dspf_pkg::IDX_CTRL) reg33 <= avs_writedata_i[7:0];
         if (ind_addr == dspf_pkg::IDX_MBOX0) mb0 <= avs_write_i; // [RQ19]
         if (ind_addr == dspf_pkg::IDX_MBOX1) mb1 <= avs_write_i; // [RQ19]
      end
   end

   // Port read result is returned in slot 1 of the following frame
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         eof_d <= 1'b0;
         rd33 <= 1'b0;
         ind_rdata_q <= 16'h0000;
      end else begin
         eof_d <= port_re;
         if (port_re) rd33 <= (cw[5:0] == dspf_pkg::IDX_CTRL);
         if (eof_d) ind_rdata_q <= rd33 ? view33 : mem_rdata; // [RQ10]
      end
   end

   assign mem_we = (port_we && cw[5:0] != dspf_pkg::IDX_CTRL) || av_we;
   assign mem_re = port_re || av_re;
   assign mem_addr = eof_pulse ? cw[5:0] : ind_addr;
   assign mem_wdata = eof_pulse ? rx_slot(rx_frame, 1) : avs_writedata_i[15:0];

   dspf_ireg_mem #(.AW(dspf_pkg::IDX_BITS), .DW(dspf_pkg::SLOT_BITS)) u_mem (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .we_i(mem_we),
      .re_i(mem_re),
      .addr_i(mem_addr),
      .wdata_i(mem_wdata),
      .rdata_o(mem_rdata)
   );

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   logic [9:0] chk_rises;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) chk_rises <= 10'h000;
      else if (slot0_load) chk_rises <= 10'h000;
      else if (rise_en) chk_rises <= chk_rises + 10'h001;
   end

   sequence s_sync_high;
      frame_sync_pin_o [*8] ##1 !frame_sync_pin_o;
   endsequence
   sequence s_slot0_start;
      state == dspf_pkg::ST_SLOTS && bit_cnt == 8'h00;
   endsequence

   chk_sync_width: assert property ($rose(frame_sync_pin_o) |-> ##1 s_sync_high) // [RQ25]
      else $error("frame sync width wrong");
   chk_sync_lead: assert property ($fell(frame_sync_pin_o) |-> s_slot0_start) // [RQ27]
      else $error("slot 0 does not follow sync");
   chk_frame_bits: assert property (slot0_load && state == dspf_pkg::ST_SLOTS |->
      chk_rises == 10'd191) // [RQ4]
      else $error("frame length not 192 bits");
   chk_ignore_pairs: assert property (sub_strobe_o != 5'h00 |->
      (sub_strobe_o & ~$past(icpt_en)) == 5'h00) // [RQ3]
      else $error("accepted a pair without intercept");
   chk_req_flags: assert property (slot0_load |=>
      req_sent == ($past(eq_mask) | ($past(icpt_en) & ~$past(sub_full_i)))) // [RQ18]
      else $error("request flag mismatch");
   chk_write_block: assert property (port_we |-> !cfg_flag || cw[dspf_pkg::CW_CLEAR]) // [RQ26]
      else $error("write while config reset set");
   chk_flag_clear: assert property (eof_pulse && cw[dspf_pkg::CW_CLEAR] && !config_reset_cmd_i
      |=> !cfg_flag) // [RQ16]
      else $error("config reset flag not cleared");
   chk_port_active: assert property (eof_pulse |=> port_active_o == $past(cw[dspf_pkg::CW_ACTIVE]))
      // [RQ11]
      else $error("active bit not forwarded");
endmodule : dspf_port_framer

// ---- dspf_dsp_model.sv ----
/*
 Partner DSP model for the serial port: waits for the frame sync, sends one
 192-bit frame MSB first and collects the reply frame.
 Assumes the framer drives the serial clock and the frame sync.
*/
`timescale 1ns/10ps
module dspf_dsp_model (
   input wire logic sclk_i,
   input wire logic sync_i,
   input wire logic sdo_i,
   input wire logic [191:0] tx_frame_i,
   output logic sdi_o,
   output logic [191:0] rx_frame_o,
   output int start_o,
   output int done_o
);
   logic armed = 1'b0;
   logic [191:0] sh = '0;
   logic [191:0] rx = '0;
   int tn = 0;
   int rn = 192;
   initial begin
      sdi_o = 1'b0;
      rx_frame_o = '0;
      start_o = 0;
      done_o = 0;
   end
   // Sample on falling edges, sync marks the next period as slot 0
   always @(negedge sclk_i) begin
      if (rn < 192) begin
         rx = {rx[190:0], sdo_i};
         rn++;
         if (rn == 192) begin
            rx_frame_o <= rx;
            done_o <= done_o + 1;
         end
      end
      if (sync_i) armed = 1'b1;
   end
   // Launch after rising edges; the line toggles between frames
   always @(posedge sclk_i) begin
      if (armed) begin
         // Each sync starts one 12-slot device frame
         armed = 1'b0;
         sh = tx_frame_i;
         tn = 192;
         rn = 0;
         start_o <= start_o + 1;
      end
      if (tn > 0) begin
         sdi_o <= sh[191];
         sh = sh << 1;
         tn--;
      end else begin
         sdi_o <= ~sdi_o;
      end
   end
endmodule : dspf_dsp_model

// ---- testbench.sv ----
/*
 Testbench for the serial port framer: Avalon master tasks, DSP model on the
 serial pins, one task per scenario.
 Assumes the design files and the DSP model are compiled first.
*/
`timescale 1ns/10ps
module testbench;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [3:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, serial_in_pin, sclk, serial_out_pin, fsync, port_active, cfg_cmd = 1'b0, fs_d = 1'b0;
   logic [159:0] tx_sample = '0, sub_sample;
   logic [4:0] tx_valid = 5'h15, sub_full = '0, rate_tick = '0, sub_strobe, strb_seen = '0;
   logic [191:0] tx_frame = '0, rx_frame;
   logic [31:0] synth_got = '0;
   logic [15:0] st, s1;
   int start_cnt, done_cnt, fail_count = 0, total_checks = 0;
   int period = 0, high_len = 0, cnt = 0, hcnt = 0, tick_cnt = 0;
   dspf_port_framer #(.SCLK_DIV(dspf_pkg::SCLK_DIV)) dut_u (.clk_i(clk_i),
      .sys_rst_i(sys_rst_i), .avs_address_i(avs_address), .avs_read_i(avs_read),
      .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
      .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
      .serial_in_pin_i(serial_in_pin), .serial_clk_o(sclk), .serial_out_pin_o(serial_out_pin),
      .frame_sync_pin_o(fsync), .tx_sample_i(tx_sample), .tx_valid_i(tx_valid),
      .sub_full_i(sub_full), .rate_tick_i(rate_tick), .powerdown_i(1'b0),
      .config_reset_cmd_i(cfg_cmd), .sub_sample_o(sub_sample), .sub_strobe_o(sub_strobe),
      .port_active_o(port_active));
   dspf_dsp_model pm_u (.sclk_i(sclk), .sync_i(fsync), .sdo_i(serial_out_pin), .tx_frame_i(tx_frame),
      .sdi_o(serial_in_pin), .rx_frame_o(rx_frame), .start_o(start_cnt), .done_o(done_cnt));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // Frame period, sync width, strobes and a synth rate tick every 2400 cycles
   always @(posedge clk_i) begin
      fs_d <= fsync;
      cnt <= (fsync && !fs_d) ? 1 : cnt + 1;
      if (fsync && !fs_d) period <= cnt;
      hcnt <= fsync ? hcnt + 1 : 0;
      if (!fsync && fs_d) high_len <= hcnt;
      if (|sub_strobe) begin
         strb_seen <= strb_seen | sub_strobe;
         synth_got <= sub_sample[64+:32];
      end
      tick_cnt <= (tick_cnt == 2399) ? 0 : tick_cnt + 1;
      rate_tick <= {2'b00, tick_cnt == 0, 2'b00};
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_i);
      while (avs_waitrequest !== 1'b0 && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      q = avs_readdata;
      if (n >= 100) fail_count++;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_i);
   endtask : av
   task automatic ind(input logic wr, input logic [5:0] i, input logic [15:0] d);
      av(1'b1, dspf_pkg::ADDR_IND_ADDR, {26'h0, i});
      av(wr, dspf_pkg::ADDR_IND_DATA, {16'h0, d});
   endtask : ind
   task automatic frm(input logic [15:0] c, input logic [15:0] d, input logic [159:0] sl);
      int s, n;
      s = start_cnt;
      n = 0;
      tx_frame[191:160] = {c & 16'h9fff, d};
      for (int k = 2; k < 12; k++) tx_frame[191-16*k-:16] = sl[16*(k-2)+:16];
      while (start_cnt == s && n < 6000) begin
         @(posedge clk_i);
         n++;
      end
      s = done_cnt;
      while (done_cnt == s && n < 6000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 6000) fail_count++;
      st = rx_frame[191:176];
      s1 = rx_frame[175:160];
   endtask : frm
   task automatic t_basic();
      frm(0, 0, 0);
      frm(0, 0, 0);
      chk(period, 192 * dspf_pkg::SCLK_DIV);
      chk(high_len, dspf_pkg::SCLK_DIV);
      chk(st, 16'hd500);
      for (int k = 2; k < 12; k++) chk(rx_frame[191-16*k-:16], tx_sample[16*(k-2)+:16]);
      av(1'b0, dspf_pkg::ADDR_STATUS, 0);
      chk(q[6:5], 2'b11);
      av(1'b0, 4'h2, 0);
      chk(q, 0);
      $display("t_basic done");
   endtask : t_basic
   task automatic t_cfgreset();
      ind(1'b1, 6'h10, 16'h0000);
      frm(16'h0010, 16'h1234, 0);
      frm(16'h0050, 0, 0);
      frm(0, 0, 0);
      chk(s1, 16'h0000);
      frm(16'h8090, 16'ha5c3, 0);
      repeat (20) @(posedge clk_i);
      chk(port_active, 1'b1);
      frm(16'h0050, 0, 0);
      frm(0, 0, 0);
      chk(st[15:14], 2'b00);
      chk(s1, 16'ha5c3);
      ind(1'b0, 6'h10, 0);
      chk(q[15:0], 16'ha5c3);
      cfg_cmd <= 1'b1;
      @(posedge clk_i);
      cfg_cmd <= 1'b0;
      frm(0, 0, 0);
      frm(0, 0, 0);
      chk(st[15:14], 2'b01);
      $display("t_cfgreset done");
   endtask : t_cfgreset
   task automatic t_mailbox();
      frm(16'h802a, 16'h0001, 0);
      frm(16'h802b, 16'h0002, 0);
      frm(16'h8000, 0, 0);
      frm(16'h8000, 0, 0);
      chk(st[7:6], 2'b11);
      frm(16'h806a, 0, 0);
      frm(16'h8000, 0, 0);
      frm(16'h8000, 0, 0);
      chk(st[7:6], 2'b10);
      ind(1'b0, dspf_pkg::IDX_CTRL, 0);
      chk(q[9:8], 2'b10);
      $display("t_mailbox done");
   endtask : t_mailbox
   task automatic t_intercept();
      logic [159:0] sl;
      sl = '0;
      sl[64+:32] = 32'h7b7b6a6a;
      sl[128+:32] = 32'hdeadbeef;
      ind(1'b1, dspf_pkg::IDX_CTRL, 16'h0020);
      frm(16'h8000, 0, 0);
      frm(16'h8000, 0, 0);
      chk(st[4:0], 5'h04);
      strb_seen = '0;
      frm(16'h8500, 0, sl);
      repeat (20) @(posedge clk_i);
      chk(strb_seen, 5'h04);
      chk(synth_got, 32'h7b7b6a6a);
      sub_full <= 5'h04;
      frm(16'h8000, 0, 0);
      frm(16'h8000, 0, 0);
      chk(st[4:0], 5'h00);
      strb_seen = '0;
      frm(16'h8400, 0, sl);
      repeat (20) @(posedge clk_i);
      chk(strb_seen, 5'h00);
      $display("t_intercept done");
   endtask : t_intercept
   task automatic t_rate();
      tx_valid <= 5'h11;
      ind(1'b1, dspf_pkg::IDX_CTRL, 16'h0003);
      repeat (3) frm(16'h8000, 0, 0);
      chk(period > 192 * dspf_pkg::SCLK_DIV, 1);
      chk({st[12:8], st[4:0]}, {5'h15, 5'h04});
      $display("t_rate done");
   endtask : t_rate
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      for (int k = 0; k < 10; k++) tx_sample[16*k+:16] = {4'h9, 4'(k), 8'h3c};
      repeat (16) @(posedge clk_i);
      chk(avs_waitrequest, 1'b1);
      chk(fsync, 1'b0);
      sys_rst_i <= 1'b0;
      t_basic();
      t_cfgreset();
      t_mailbox();
      t_intercept();
      t_rate();
      report_and_stop();
   end
   initial begin
      #900000;
      fail_count++;
      report_and_stop();
   end
endmodule : testbench
